// [include/lie_pkg.sv]
// Constants for the link interrupt event source block
// Assumes a 32-bit register port with byte offsets as addresses
package lie_pkg;
    // Register byte offsets
    localparam logic [7:0] EVENT_SET_ADDR = 8'h80;
    localparam logic [7:0] EVENT_CLR_ADDR = 8'h84;
    localparam logic [7:0] MASK_SET_ADDR = 8'h88;
    localparam logic [7:0] MASK_CLR_ADDR = 8'h8c;
    localparam logic [7:0] ISO_TX_EV_SET_ADDR = 8'h90;
    localparam logic [7:0] ISO_TX_EV_CLR_ADDR = 8'h94;
    localparam logic [7:0] ISO_TX_MK_SET_ADDR = 8'h98;
    localparam logic [7:0] ISO_TX_MK_CLR_ADDR = 8'h9c;
    localparam logic [7:0] ISO_RX_EV_SET_ADDR = 8'ha0;
    localparam logic [7:0] ISO_RX_EV_CLR_ADDR = 8'ha4;
    localparam logic [7:0] ISO_RX_MK_SET_ADDR = 8'ha8;
    localparam logic [7:0] ISO_RX_MK_CLR_ADDR = 8'hac;
    // Event bit positions
    localparam int BIT_CYCLE_MISMATCH = 23;
    localparam int BIT_LOST_CYCLE = 22;
    localparam int BIT_SIXTY_FOUR = 21;
    localparam int BIT_NEW_CYCLE = 20;
    localparam int BIT_PHY_REQ = 19;
    localparam int BIT_BUS_RESET = 17;
    localparam int BIT_SELF_ID_DONE = 16;
    localparam int BIT_LOCK_RESP_ERR = 9;
    localparam int BIT_POSTED_WR_ERR = 8;
    localparam int BIT_ISO_RX_SUM = 7;
    localparam int BIT_ISO_TX_SUM = 6;
    localparam int BIT_GLOBAL_EN = 31;
    localparam int SECONDS_WATCH_BIT = 7;
    // Latched event bits: 23..19, 17, 16, 9, 8, 5..0
    localparam logic [31:0] LATCH_BITS = 32'h00fb_033f;
    localparam logic [31:0] MASK_BITS = 32'h80fb_03ff;
    localparam logic [31:0] EVENT_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    // Iso context count
    localparam int ISO_CTX = 8;
    localparam logic [7:0] ISO_RESET = 8'h00;
    // Cycle timer widths
    localparam int SEC_W = 7;
    localparam int CNT_W = 13;
endpackage

// [src/lie_event_sources.sv]
// Link interrupt event register bits 23..0, mask and iso summaries
// Assumes all event inputs are synchronous to clk_sys_i
//
// Operation
// - Cycle start time mismatch sets bit 23
// - No cycle start between new cycles sets 22
// - Predicted lost cycle may set 22 early
// - Seconds bit seven change sets bit 21
// - Cycle count low bit toggle sets 20
// - PHY status interrupt request sets 19
// - Bits 18 and 15..10 read zero
// - Bus reset entry sets bit 17
// - Self-ID stream received sets bit 16
// - Bus reset entry edge clears self-ID done; a set write of bit 17 does not
// - Lock response without ack complete sets 9
// - Host error on posted write sets 8
// - Bit 7 is OR of masked rx events
// - Bit 6 is OR of masked tx events
// - Response packet stored sets bit 5
// - Request packet stored sets bit 4
// - Receive response descriptor done sets 3
// - Receive request descriptor done sets 2
// - Response transmit command done sets 1
// - Request transmit command done sets 0
// - Rising edge or set write; clear write clears
// - Clear address read returns event AND mask
// - No interrupt without global enable
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module lie_event_sources
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Cycle timing
    input wire logic [6:0] local_cycle_timer_seconds_i,
    input wire logic [12:0] local_cycle_timer_count_i,
    input wire logic cycle_start_rx_i,
    input wire logic cycle_start_tx_i,
    input wire logic [6:0] cycle_start_seconds_i,
    input wire logic [12:0] cycle_start_count_i,
    input wire logic subaction_gap_i,
    input wire logic arb_reset_gap_i,
    // PHY and bus
    input wire logic phy_status_irq_i,
    input wire logic phy_bus_reset_i,
    input wire logic self_id_stream_done_i,
    // Error and DMA completion levels
    input wire logic lock_resp_no_ack_i,
    input wire logic posted_write_host_err_i,
    input wire logic response_packet_stored_i,
    input wire logic request_packet_stored_i,
    input wire logic async_receive_response_dma_i,
    input wire logic async_receive_request_dma_i,
    input wire logic response_transmit_done_i,
    input wire logic request_transmit_done_i,
    // Iso context event sources
    input wire logic [7:0] iso_rx_ctx_i,
    input wire logic [7:0] iso_tx_ctx_i,
    // Interrupt
    output logic irq_o
);

    logic [31:0] link_interrupt_event;
    logic [31:0] link_interrupt_mask;
    logic [7:0] iso_receive_context_events;
    logic [7:0] iso_receive_context_mask;
    logic [7:0] iso_transmit_context_events;
    logic [7:0] iso_transmit_context_mask;
    logic [31:0] src_level;
    logic [31:0] src_prev;
    logic [31:0] src_rise;
    logic [31:0] ev_set_wr;
    logic [31:0] ev_clr_wr;
    logic [31:0] next_event;
    logic [31:0] event_view;
    logic [7:0] iso_rx_prev;
    logic [7:0] iso_tx_prev;
    logic iso_receive_summary;
    logic iso_transmit_summary;
    logic seconds_b7_prev;
    logic count_b0_prev;
    logic new_cycle;
    logic saw_cycle_start;
    logic first_gap_seen;
    logic cycle_mismatch;
    logic lost_now;
    logic lost_pred;
    logic [31:0] next_rdata;

    // Cycle timer watchers
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            seconds_b7_prev <= 1'b0;
            count_b0_prev <= 1'b0;
        end
        else
        begin
            seconds_b7_prev <= local_cycle_timer_seconds_i[6];
            count_b0_prev <= local_cycle_timer_count_i[0];
        end
    end

    assign new_cycle = local_cycle_timer_count_i[0] ^ count_b0_prev;

    // Cycle start bookkeeping within each cycle
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            saw_cycle_start <= 1'b1;
            first_gap_seen <= 1'b1;
        end
        else if (new_cycle)
        begin
            saw_cycle_start <= 1'b0;
            first_gap_seen <= 1'b0;
        end
        else
        begin
            if (cycle_start_rx_i || cycle_start_tx_i)
            begin
                saw_cycle_start <= 1'b1;
            end
            if (subaction_gap_i)
            begin
                first_gap_seen <= 1'b1;
            end
        end
    end

    assign cycle_mismatch = cycle_start_rx_i
        && ((cycle_start_seconds_i != local_cycle_timer_seconds_i)
        || (cycle_start_count_i != local_cycle_timer_count_i));
    assign lost_now = new_cycle && !saw_cycle_start
        && !(cycle_start_rx_i || cycle_start_tx_i);
    assign lost_pred = !saw_cycle_start && !new_cycle
        && ((first_gap_seen && !cycle_start_rx_i && !cycle_start_tx_i)
        || arb_reset_gap_i);

    // Source levels at event bit positions
    always_comb
    begin
        src_level = 32'h0000_0000;
        src_level[lie_pkg::BIT_CYCLE_MISMATCH] = cycle_mismatch;
        src_level[lie_pkg::BIT_LOST_CYCLE] = lost_now || lost_pred;
        src_level[lie_pkg::BIT_SIXTY_FOUR] =
            local_cycle_timer_seconds_i[6] ^ seconds_b7_prev;
        src_level[lie_pkg::BIT_NEW_CYCLE] = new_cycle;
        src_level[lie_pkg::BIT_PHY_REQ] = phy_status_irq_i;
        src_level[lie_pkg::BIT_BUS_RESET] = phy_bus_reset_i;
        src_level[lie_pkg::BIT_SELF_ID_DONE] = self_id_stream_done_i;
        src_level[lie_pkg::BIT_LOCK_RESP_ERR] = lock_resp_no_ack_i;
        src_level[lie_pkg::BIT_POSTED_WR_ERR] =
            posted_write_host_err_i;
        src_level[5] = response_packet_stored_i;
        src_level[4] = request_packet_stored_i;
        src_level[3] = async_receive_response_dma_i;
        src_level[2] = async_receive_request_dma_i;
        src_level[1] = response_transmit_done_i;
        src_level[0] = request_transmit_done_i;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            src_prev <= 32'h0000_0000;
        end
        else
        begin
            src_prev <= src_level;
        end
    end

    assign src_rise = src_level & ~src_prev;
    assign ev_set_wr = (reg_wr_i && reg_addr_i == lie_pkg::EVENT_SET_ADDR)
        ? reg_wdata_i : 32'h0000_0000;
    assign ev_clr_wr = (reg_wr_i && reg_addr_i == lie_pkg::EVENT_CLR_ADDR)
        ? reg_wdata_i : 32'h0000_0000;

    // Event register update; set beats clear
    always_comb
    begin
        next_event = (link_interrupt_event & ~ev_clr_wr)
            | ((src_rise | ev_set_wr) & lie_pkg::LATCH_BITS);
        if (src_rise[lie_pkg::BIT_BUS_RESET])
        begin
            next_event[lie_pkg::BIT_SELF_ID_DONE] = 1'b0;
        end
        next_event = next_event & lie_pkg::LATCH_BITS;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            link_interrupt_event <= lie_pkg::EVENT_RESET;
        end
        else
        begin
            link_interrupt_event <= next_event;
        end
    end

    // Mask register
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            link_interrupt_mask <= lie_pkg::MASK_RESET;
        end
        else if (reg_wr_i && reg_addr_i == lie_pkg::MASK_SET_ADDR)
        begin
            link_interrupt_mask <= (link_interrupt_mask | reg_wdata_i)
                & lie_pkg::MASK_BITS;
        end
        else if (reg_wr_i && reg_addr_i == lie_pkg::MASK_CLR_ADDR)
        begin
            link_interrupt_mask <= link_interrupt_mask & ~reg_wdata_i;
        end
    end

    // Iso context event and mask registers
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            iso_rx_prev <= lie_pkg::ISO_RESET;
            iso_tx_prev <= lie_pkg::ISO_RESET;
            iso_receive_context_events <= lie_pkg::ISO_RESET;
            iso_transmit_context_events <= lie_pkg::ISO_RESET;
        end
        else
        begin
            iso_rx_prev <= iso_rx_ctx_i;
            iso_tx_prev <= iso_tx_ctx_i;
            iso_receive_context_events <= (iso_receive_context_events
                & ~((reg_wr_i && reg_addr_i == lie_pkg::ISO_RX_EV_CLR_ADDR)
                ? reg_wdata_i[7:0] : 8'h00))
                | (iso_rx_ctx_i & ~iso_rx_prev)
                | ((reg_wr_i && reg_addr_i == lie_pkg::ISO_RX_EV_SET_ADDR)
                ? reg_wdata_i[7:0] : 8'h00);
            iso_transmit_context_events <= (iso_transmit_context_events
                & ~((reg_wr_i && reg_addr_i == lie_pkg::ISO_TX_EV_CLR_ADDR)
                ? reg_wdata_i[7:0] : 8'h00))
                | (iso_tx_ctx_i & ~iso_tx_prev)
                | ((reg_wr_i && reg_addr_i == lie_pkg::ISO_TX_EV_SET_ADDR)
                ? reg_wdata_i[7:0] : 8'h00);
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            iso_receive_context_mask <= lie_pkg::ISO_RESET;
            iso_transmit_context_mask <= lie_pkg::ISO_RESET;
        end
        else if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                lie_pkg::ISO_RX_MK_SET_ADDR:
                    iso_receive_context_mask <=
                        iso_receive_context_mask | reg_wdata_i[7:0];
                lie_pkg::ISO_RX_MK_CLR_ADDR:
                    iso_receive_context_mask <=
                        iso_receive_context_mask & ~reg_wdata_i[7:0];
                lie_pkg::ISO_TX_MK_SET_ADDR:
                    iso_transmit_context_mask <=
                        iso_transmit_context_mask | reg_wdata_i[7:0];
                lie_pkg::ISO_TX_MK_CLR_ADDR:
                    iso_transmit_context_mask <=
                        iso_transmit_context_mask & ~reg_wdata_i[7:0];
                default:
                    iso_receive_context_mask <= iso_receive_context_mask;
            endcase
        end
    end

    assign iso_receive_summary =
        |(iso_receive_context_events & iso_receive_context_mask);
    assign iso_transmit_summary =
        |(iso_transmit_context_events & iso_transmit_context_mask);

    always_comb
    begin
        event_view = link_interrupt_event;
        event_view[lie_pkg::BIT_ISO_RX_SUM] = iso_receive_summary;
        event_view[lie_pkg::BIT_ISO_TX_SUM] = iso_transmit_summary;
    end

    // Interrupt output
    assign irq_o = link_interrupt_mask[lie_pkg::BIT_GLOBAL_EN]
        && |(event_view & link_interrupt_mask
        & ~(32'h1 << lie_pkg::BIT_GLOBAL_EN));

    // Read data mux
    always_comb
    begin
        unique case (reg_addr_i)
            lie_pkg::EVENT_SET_ADDR:
                next_rdata = event_view;
            lie_pkg::EVENT_CLR_ADDR:
                next_rdata = event_view & link_interrupt_mask;
            lie_pkg::MASK_SET_ADDR, lie_pkg::MASK_CLR_ADDR:
                next_rdata = link_interrupt_mask;
            lie_pkg::ISO_TX_EV_SET_ADDR:
                next_rdata = {24'h000000, iso_transmit_context_events};
            lie_pkg::ISO_TX_EV_CLR_ADDR:
                next_rdata = {24'h000000,
                    iso_transmit_context_events & iso_transmit_context_mask};
            lie_pkg::ISO_TX_MK_SET_ADDR, lie_pkg::ISO_TX_MK_CLR_ADDR:
                next_rdata = {24'h000000, iso_transmit_context_mask};
            lie_pkg::ISO_RX_EV_SET_ADDR:
                next_rdata = {24'h000000, iso_receive_context_events};
            lie_pkg::ISO_RX_EV_CLR_ADDR:
                next_rdata = {24'h000000,
                    iso_receive_context_events & iso_receive_context_mask};
            lie_pkg::ISO_RX_MK_SET_ADDR, lie_pkg::ISO_RX_MK_CLR_ADDR:
                next_rdata = {24'h000000, iso_receive_context_mask};
            default:
                next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            reg_rdata_o <= 32'h0000_0000;
        end
        else if (reg_rd_i)
        begin
            reg_rdata_o <= next_rdata;
        end
        else
        begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    // Checks
    default clocking chk_clk @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    a_reserved_zero: assert property (
        link_interrupt_event[18] == 1'b0
        && link_interrupt_event[15:10] == 6'h00)
        else $error("Reserved event bits set");
    a_bus_reset_event_sets: assert property (
        phy_bus_reset_i && !src_prev[lie_pkg::BIT_BUS_RESET] |=>
        link_interrupt_event[lie_pkg::BIT_BUS_RESET]
        && !link_interrupt_event[lie_pkg::BIT_SELF_ID_DONE])
        else $error("Bus reset did not set or self-ID not cleared");
    a_set_over_clear: assert property (
        src_rise[0] |=> link_interrupt_event[0])
        else $error("Source edge lost");
    a_clear_works: assert property (
        reg_wr_i && reg_addr_i == lie_pkg::EVENT_CLR_ADDR && reg_wdata_i[1]
        && !src_rise[1] |=> !link_interrupt_event[1])
        else $error("Clear write ignored");
    a_global_gate: assert property (
        !link_interrupt_mask[lie_pkg::BIT_GLOBAL_EN] |-> !irq_o)
        else $error("Interrupt without global enable");
    a_irq_pending: assert property (
        link_interrupt_mask[31] && link_interrupt_mask[5]
        && link_interrupt_event[5] |-> irq_o)
        else $error("Enabled event without interrupt");
    a_clr_read: assert property (
        reg_rd_i && reg_addr_i == lie_pkg::EVENT_CLR_ADDR |=>
        reg_rdata_o == ($past(event_view) & $past(link_interrupt_mask)))
        else $error("Clear address read wrong");
    a_sixty_four: assert property (
        $changed(local_cycle_timer_seconds_i[6]) |=> link_interrupt_event[21])
        else $error("Seconds bit change missed");
    a_lost_cycle: assert property (
        src_rise[lie_pkg::BIT_LOST_CYCLE] |=>
        link_interrupt_event[lie_pkg::BIT_LOST_CYCLE])
        else $error("Lost cycle not latched");

endmodule // lie_event_sources

`default_nettype wire

// [testbench/test_lie_event_sources.sv]
// Self-checking bench for the link interrupt event source block
// Assumes the register port of lie_event_sources and lie_pkg constants
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
        n_mismatch++; \
        $display("[ERR] %0t got %h exp %h", $time, got, exp); \
    end \
end

module test_lie_event_sources;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [6:0] lsec = 7'h00;
    logic [12:0] lcnt = 13'h0000;
    logic csrx = 1'b0;
    logic cstx = 1'b0;
    logic [6:0] csec = 7'h00;
    logic [12:0] ccnt = 13'h0000;
    logic sag = 1'b0;
    logic arg = 1'b0;
    logic [10:0] lvl = 11'h000;
    logic [7:0] isorx = 8'h00;
    logic [7:0] isotx = 8'h00;
    logic irq;
    int n_mismatch = 0;
    int cmp_count = 0;
    int bitpos [11] = '{19, 17, 16, 9, 8, 5, 4, 3, 2, 1, 0};
    logic [7:0] idle_addr [9] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h90,
                                  8'h98, 8'ha0, 8'ha8, 8'h40};
    logic [31:0] bit_v;
    logic [7:0] base;

    lie_event_sources lie_event_sources_i (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata),
        .local_cycle_timer_seconds_i(lsec),
        .local_cycle_timer_count_i(lcnt),
        .cycle_start_rx_i(csrx), .cycle_start_tx_i(cstx),
        .cycle_start_seconds_i(csec), .cycle_start_count_i(ccnt),
        .subaction_gap_i(sag), .arb_reset_gap_i(arg),
        .phy_status_irq_i(lvl[0]), .phy_bus_reset_i(lvl[1]),
        .self_id_stream_done_i(lvl[2]), .lock_resp_no_ack_i(lvl[3]),
        .posted_write_host_err_i(lvl[4]),
        .response_packet_stored_i(lvl[5]),
        .request_packet_stored_i(lvl[6]),
        .async_receive_response_dma_i(lvl[7]),
        .async_receive_request_dma_i(lvl[8]),
        .response_transmit_done_i(lvl[9]),
        .request_transmit_done_i(lvl[10]),
        .iso_rx_ctx_i(isorx), .iso_tx_ctx_i(isotx), .irq_o(irq)
    );

    initial
    begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask

    // Read and compare the masked word
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1;
        `CHK(rdata & m, e)
    endtask

    task automatic cyc_start(input logic tx, input logic [6:0] s,
                             input logic [12:0] c);
        @(posedge clk_sys_i);
        csrx <= ~tx;
        cstx <= tx;
        csec <= s;
        ccnt <= c;
        @(posedge clk_sys_i);
        csrx <= 1'b0;
        cstx <= 1'b0;
    endtask

    task automatic new_cycle();
        @(posedge clk_sys_i);
        lcnt <= lcnt ^ 13'h0001;
    endtask

    task automatic give_verdict();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #100000;
        n_mismatch++;
        give_verdict();
    end

    initial
    begin
        repeat (2) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        foreach (idle_addr[i])
            chk_rd(idle_addr[i], 32'h0, 32'hffff_ffff);
        #1 `CHK(irq, 1'b0)
        // Set and clear writes, reserved bits stay zero
        wr_reg(8'h80, 32'hffff_ffff);
        chk_rd(8'h80, 32'h00fb_033f, 32'hffff_ffff);
        wr_reg(8'h84, 32'hffff_ffff);
        chk_rd(8'h80, 32'h0, 32'hffff_ffff);
        // Level sources: edge sets, held level does not set again
        foreach (bitpos[k])
        begin
            bit_v = 32'h1 << bitpos[k];
            @(posedge clk_sys_i);
            lvl[k] <= 1'b1;
            chk_rd(8'h80, bit_v, 32'hffff_ffff);
            wr_reg(8'h84, bit_v);
            chk_rd(8'h80, 32'h0, 32'hffff_ffff);
            @(posedge clk_sys_i);
            lvl[k] <= 1'b0;
        end
        // Bus reset drops self-ID done
        wr_reg(8'h80, 32'h0001_0000);
        @(posedge clk_sys_i);
        lvl[1] <= 1'b1;
        chk_rd(8'h80, 32'h0002_0000, 32'hffff_ffff);
        @(posedge clk_sys_i);
        lvl[1] <= 1'b0;
        wr_reg(8'h84, 32'hffff_ffff);
        // Mask, masked read and global enable
        wr_reg(8'h88, 32'h0000_0001);
        wr_reg(8'h80, 32'h0000_0003);
        #1 `CHK(irq, 1'b0)
        chk_rd(8'h84, 32'h0000_0001, 32'hffff_ffff);
        wr_reg(8'h88, 32'h8000_0000);
        #1 `CHK(irq, 1'b1)
        chk_rd(8'h8c, 32'h8000_0001, 32'hffff_ffff);
        wr_reg(8'h84, 32'h0000_0001);
        #1 `CHK(irq, 1'b0)
        wr_reg(8'h84, 32'hffff_ffff);
        wr_reg(8'h8c, 32'hffff_ffff);
        // Iso summaries follow masked context events
        for (int j = 0; j < 2; j++)
        begin
            base = (j == 0) ? 8'ha0 : 8'h90;
            bit_v = (j == 0) ? 32'h80 : 32'h40;
            @(posedge clk_sys_i);
            isorx <= (j == 0) ? 8'h04 : 8'h00;
            isotx <= (j == 0) ? 8'h00 : 8'h04;
            chk_rd(8'h80, 32'h0, 32'hffff_ffff);
            wr_reg(base + 8'h08, 32'h0000_0004);
            chk_rd(8'h80, bit_v, 32'hffff_ffff);
            chk_rd(base + 8'h04, 32'h0000_0004, 32'hffff_ffff);
            wr_reg(base + 8'h0c, 32'h0000_00ff);
            chk_rd(8'h80, 32'h0, 32'hffff_ffff);
            chk_rd(base, 32'h0000_0004, 32'hffff_ffff);
            chk_rd(base + 8'h04, 32'h0, 32'hffff_ffff);
            wr_reg(base + 8'h04, 32'h0000_00ff);
        end
        // Cycle timing events
        new_cycle();
        chk_rd(8'h80, 32'h0010_0000, 32'h0010_0000);
        @(posedge clk_sys_i);
        lsec <= lsec ^ 7'h40;
        chk_rd(8'h80, 32'h0020_0000, 32'h0020_0000);
        cyc_start(1'b0, lsec, lcnt);
        new_cycle();
        chk_rd(8'h80, 32'h0, 32'h0080_0000);
        wr_reg(8'h84, 32'hffff_ffff);
        new_cycle();
        chk_rd(8'h80, 32'h0040_0000, 32'h0040_0000);
        for (int k = 0; k < 2; k++)
        begin
            cyc_start(1'b1, lsec, lcnt);
            new_cycle();
            wr_reg(8'h84, 32'hffff_ffff);
            @(posedge clk_sys_i);
            sag <= (k == 0);
            arg <= (k == 1);
            @(posedge clk_sys_i);
            sag <= 1'b0;
            arg <= 1'b0;
            chk_rd(8'h80, 32'h0040_0000, 32'h0040_0000);
        end
        cyc_start(1'b0, lsec ^ 7'h01, lcnt);
        chk_rd(8'h80, 32'h0080_0000, 32'h0080_0000);
        give_verdict();
    end
endmodule // test_lie_event_sources

`default_nettype wire
